// File: logic/backlight_fade_gpio_ctrl.sv
`timescale 1ns/100ps
// Purpose: backlight control, fade engine and pin control registers
// Assumes: serial port engine supplies byte writes/reads, pins raw
// Notes: writes take effect on the cycle after the strobe
module backlight_fade_gpio_ctrl
   import bl_pkg::*;
#(
   parameter int STEP_SLOW = bl_pkg::STEP_SLOW_CYC,
   parameter int STEP_FAST = bl_pkg::STEP_FAST_CYC
)
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_write,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   output logic             reg_hit,
   input  wire logic [2:0]  pin_in,
   output logic      [2:0]  pin_out,
   output logic      [2:0]  pin_oe,
   output logic      [7:0]  primary_code,
   output logic      [7:0]  secondary_code,
   output logic             primary_on,
   output logic             secondary_on
);
   import bl_pkg::*;

   logic [7:0]  control_q;
   logic [7:0]  primary_q;
   logic [7:0]  secondary_q;
   logic [7:0]  direction_q;
   logic [7:0]  level_q;
   logic [7:0]  ext_dim_q;
   logic [2:0]  pin_meta_q;
   logic [2:0]  pin_sync_q;
   logic [31:0] step_cnt_q;
   logic        tick_q;
   logic [7:0]  rdata_q;

   fade_if fade_p ();
   fade_if fade_s ();

   // register decode
   wire hit_control   = reg_addr == OFS_CONTROL;
   wire hit_primary   = reg_addr == OFS_PRIMARY;
   wire hit_secondary = reg_addr == OFS_SECONDARY;
   wire hit_direction = reg_addr == OFS_DIRECTION;
   wire hit_level     = reg_addr == OFS_LEVEL;
   wire hit_ext_dim   = reg_addr == OFS_EXT_DIM;
   wire any_hit = hit_control | hit_primary | hit_secondary | hit_direction | hit_level
                | hit_ext_dim;
   assign reg_hit = any_hit;

   // control fields
   wire fade_fast   = control_q[BIT_FADE_RATE];
   wire fade_to_sec = control_q[BIT_FADE_TARGET];
   wire fade_en     = control_q[BIT_FADE_EN];
   wire shared      = control_q[BIT_SHARED];
   wire dim_pin_en  = direction_q[BIT_DIM_PIN_EN];

   // which channel ramps: shared with primary target fades both
   wire fade_prim = fade_en && !fade_to_sec;
   wire fade_sec  = fade_en && (fade_to_sec || shared);

   // register writes
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         control_q   <= RESET_VALUE;
         primary_q   <= RESET_VALUE;
         secondary_q <= RESET_VALUE;
         direction_q <= RESET_VALUE;
         level_q     <= RESET_VALUE;
         ext_dim_q   <= RESET_VALUE;
      end
      else if (ce && reg_write)
      begin
         if (hit_control)   control_q   <= {2'b00, reg_wdata[5:0]};
         if (hit_primary)   primary_q   <= reg_wdata;
         if (hit_secondary) secondary_q <= reg_wdata;
         if (hit_direction) direction_q <= {3'b000, reg_wdata[4], 1'b0, reg_wdata[2:0]};
         if (hit_level)     level_q     <= {5'b00000, reg_wdata[2:0]};
         if (hit_ext_dim)   ext_dim_q   <= {6'b000000, reg_wdata[1:0]};
      end
   end

   // pin synchroniser, two stages
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pin_meta_q <= 3'h0;
         pin_sync_q <= 3'h0;
      end
      else if (ce)
      begin
         pin_meta_q <= pin_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   // shared step timer: full-scale time over 255 codes
   wire [31:0] step_len = fade_fast ? 32'(STEP_FAST) : 32'(STEP_SLOW);
   wire        step_end = step_cnt_q >= step_len - 32'h0000_0001;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         step_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b0;
      end
      else if (ce)
      begin
         step_cnt_q <= (step_end || !fade_en) ? 32'h0000_0000 : step_cnt_q + 32'h0000_0001;
         tick_q     <= step_end && fade_en;
      end
   end

   // fade channel inputs
   assign fade_p.target  = primary_q;
   assign fade_p.fade_on = fade_prim;
   assign fade_p.fast    = fade_fast;
   assign fade_p.tick    = tick_q;
   assign fade_s.target  = shared ? primary_q : secondary_q;
   assign fade_s.fade_on = fade_sec;
   assign fade_s.fast    = fade_fast;
   assign fade_s.tick    = tick_q;

   fade_ramp u_ramp_p (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .ch    (fade_p)
   );
   fade_ramp u_ramp_s (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .ch    (fade_s)
   );

   // shared mode: secondary follows primary live code unless it fades alone
   wire [7:0] sec_live = (shared && !fade_to_sec) ? fade_p.code : fade_s.code;
   assign primary_code   = fade_p.code;
   assign secondary_code = sec_live;

   // external dimming gate on pin 0 only
   wire dim_level = pin_sync_q[0];
   wire gate_p = !(dim_pin_en && ext_dim_q[BIT_DIM_PRIMARY]) || dim_level;
   wire gate_s = !(dim_pin_en && ext_dim_q[BIT_DIM_SECOND]) || dim_level;
   assign primary_on   = control_q[BIT_EN_PRIMARY] && gate_p;
   assign secondary_on = control_q[BIT_EN_SECOND] && gate_s;

   // pin drivers: dimming enable forces pin 0 to input
   wire [2:0] dir_bits = direction_q[2:0];
   assign pin_oe  = {dir_bits[2:1], dir_bits[0] && !dim_pin_en};
   assign pin_out = level_q[2:0] & pin_oe;

   // read data, registered
   wire [7:0] rd_mux =
        hit_control   ? control_q
      : hit_primary   ? primary_q
      : hit_secondary ? secondary_q
      : hit_direction ? direction_q
      : hit_level     ? {5'b00000, pin_sync_q}
      : hit_ext_dim   ? ext_dim_q
      : 8'h00;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdata_q <= 8'h00;
      else if (ce && reg_read)
         rdata_q <= rd_mux;
   end
   assign reg_rdata = rdata_q;

   // checks
   sequence dim_pin_set;
      dim_pin_en;
   endsequence
   pin0_input_a: assert property (@(posedge clock) disable iff (rst)
      dim_pin_set |-> !pin_oe[0])
      else $error("pin 0 driven while dimming");
   out_level_a: assert property (@(posedge clock) disable iff (rst)
      pin_oe[1] |-> pin_out[1] == level_q[1])
      else $error("pin 1 level wrong");
   dir_zero_a: assert property (@(posedge clock) disable iff (rst)
      !direction_q[2] |-> !pin_oe[2])
      else $error("pin 2 driven as input");
   dim_off_a: assert property (@(posedge clock) disable iff (rst)
      dim_pin_en && ext_dim_q[BIT_DIM_PRIMARY] && !pin_sync_q[0] |-> !primary_on)
      else $error("primary lit with dim low");
   no_dim_a: assert property (@(posedge clock) disable iff (rst)
      !ext_dim_q[BIT_DIM_SECOND] |-> secondary_on == control_q[BIT_EN_SECOND])
      else $error("secondary gated without enable");
   shared_a: assert property (@(posedge clock) disable iff (rst)
      shared && !fade_to_sec |-> secondary_code == primary_code)
      else $error("shared mode mismatch");
   write_code_a: assert property (@(posedge clock) disable iff (rst)
      ce && reg_write && hit_primary |=> primary_q == $past(reg_wdata))
      else $error("primary code not stored");
   tick_gap_a: assert property (@(posedge clock) disable iff (rst)
      ce && tick_q |=> !tick_q)
      else $error("fade steps too close");
   level_read_a: assert property (@(posedge clock) disable iff (rst)
      ce && reg_read && hit_level |=> reg_rdata == {5'b00000, $past(pin_sync_q)})
      else $error("level read not pin state");

   // fade steps: a tick moves a live code one code toward its target
   sequence prim_rising;
      ce && fade_prim && tick_q && (fade_p.code < primary_q);
   endsequence
   sequence prim_falling;
      ce && fade_prim && tick_q && (fade_p.code > primary_q);
   endsequence
   sequence sec_rising;
      ce && fade_sec && tick_q && (fade_s.code < fade_s.target);
   endsequence
   sequence sec_falling;
      ce && fade_sec && tick_q && (fade_s.code > fade_s.target);
   endsequence
   prim_up_a: assert property (@(posedge clock) disable iff (rst)
      prim_rising |=> fade_p.code == $past(fade_p.code) + 8'h01)
      else $error("primary step up wrong");
   prim_down_a: assert property (@(posedge clock) disable iff (rst)
      prim_falling |=> fade_p.code == $past(fade_p.code) - 8'h01)
      else $error("primary step down wrong");
   sec_up_a: assert property (@(posedge clock) disable iff (rst)
      sec_rising |=> fade_s.code == $past(fade_s.code) + 8'h01)
      else $error("secondary step up wrong");
   sec_down_a: assert property (@(posedge clock) disable iff (rst)
      sec_falling |=> fade_s.code == $past(fade_s.code) - 8'h01)
      else $error("secondary step down wrong");

   // step counter stays inside the selected interval once the rate is steady
   step_bound_a: assert property (@(posedge clock) disable iff (rst)
      ce && fade_en && $stable(fade_fast) |-> step_cnt_q < step_len)
      else $error("step interval overrun");

   // register stores, unused control bits kept at zero
   ctrl_store_a: assert property (@(posedge clock) disable iff (rst)
      ce && reg_write && hit_control |=> control_q[5:0] == $past(reg_wdata[5:0])
         && control_q[7:6] == 2'b00)
      else $error("control not stored");
   sec_store_a: assert property (@(posedge clock) disable iff (rst)
      ce && reg_write && hit_secondary |=> secondary_q == $past(reg_wdata))
      else $error("secondary code not stored");
   dir_store_a: assert property (@(posedge clock) disable iff (rst)
      ce && reg_write && hit_direction |=> direction_q[4] == $past(reg_wdata[4])
         && direction_q[2:0] == $past(reg_wdata[2:0]))
      else $error("direction not stored");
   level_store_a: assert property (@(posedge clock) disable iff (rst)
      ce && reg_write && hit_level |=> level_q[2:0] == $past(reg_wdata[2:0]))
      else $error("level not stored");
   dim_store_a: assert property (@(posedge clock) disable iff (rst)
      ce && reg_write && hit_ext_dim |=> ext_dim_q[1:0] == $past(reg_wdata[1:0]))
      else $error("dimming enables not stored");

   // fade routing between the two channels
   both_fade_a: assert property (@(posedge clock) disable iff (rst)
      fade_en && shared && !fade_to_sec |-> fade_p.fade_on && fade_s.fade_on)
      else $error("shared fade not on both");
   sec_alone_a: assert property (@(posedge clock) disable iff (rst)
      fade_en && fade_to_sec |-> !fade_p.fade_on && fade_s.fade_on)
      else $error("secondary target fade misrouted");
   shared_target_a: assert property (@(posedge clock) disable iff (rst)
      shared |-> fade_s.target == primary_q)
      else $error("shared target not primary");

   // pins and dimming gate
   upper_pins_a: assert property (@(posedge clock) disable iff (rst)
      pin_oe[2:1] == direction_q[2:1])
      else $error("pins 1 and 2 direction wrong");
   pin0_out_a: assert property (@(posedge clock) disable iff (rst)
      !dim_pin_en && direction_q[0] |-> pin_oe[0] && pin_out[0] == level_q[0])
      else $error("pin 0 output wrong");
   dim_high_a: assert property (@(posedge clock) disable iff (rst)
      dim_pin_en && pin_sync_q[0] |-> primary_on == control_q[BIT_EN_PRIMARY]
         && secondary_on == control_q[BIT_EN_SECOND])
      else $error("strings gated with dim high");
   prim_no_dim_a: assert property (@(posedge clock) disable iff (rst)
      !ext_dim_q[BIT_DIM_PRIMARY] |-> primary_on == control_q[BIT_EN_PRIMARY])
      else $error("primary gated without enable");

   // read data stands until the next read, unmapped reads give zero
   rdata_hold_a: assert property (@(posedge clock) disable iff (rst)
      !(ce && reg_read) |=> $stable(reg_rdata))
      else $error("read data moved without read");
   unmapped_read_a: assert property (@(posedge clock) disable iff (rst)
      ce && reg_read && !any_hit |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   // clock enable low freezes registers, timer and ramps
   ce_hold_a: assert property (@(posedge clock) disable iff (rst)
      !ce |=> $stable(control_q) && $stable(primary_q) && $stable(step_cnt_q)
         && $stable(fade_p.code) && $stable(fade_s.code))
      else $error("state moved with enable low");

   // reset held across an edge clears registers, strings and pin drivers
   sequence held_in_reset;
      rst ##1 rst;
   endsequence
   reset_zero_a: assert property (@(posedge clock)
      held_in_reset |-> control_q == RESET_VALUE && primary_q == RESET_VALUE
         && secondary_q == RESET_VALUE && direction_q == RESET_VALUE
         && level_q == RESET_VALUE && ext_dim_q == RESET_VALUE
         && pin_oe == 3'h0 && !primary_on && !secondary_on)
      else $error("state not cleared by reset");
endmodule

// File: logic/bl_pkg.sv
// Purpose: shared constants for the backlight fade and pin control block
// Assumes: 100 MHz system clock, byte-wide register port at 8-bit addresses
// Notes: all offsets, fields, reset values and timing counts live here
// Functional notes
// - full-scale fade takes 1.3 s slow, 0.65 s fast
// - partial fades keep the full-scale ramp rate
// - control bit 5 selects fade rate
// - bit 4 picks fade target, bit 3 enables fade
// - bit 2 shared mode, bits 1/0 enable strings
// - shared mode with primary target fades both strings
// - 8-bit current codes at 04h and 05h, 0.1 mA steps
// - only pin 0 can be the dimming input
// - dimming enable bit 4 forces pin 0 input
// - direction bits 2:0, one means output
// - output pins drive their level register bit
// - level register reads sampled pin states
// - dimming input high turns strings on, low off
// - dimming applies only to strings enabled at 2bh
package bl_pkg;
   localparam logic [7:0] OFS_CONTROL   = 8'h03;
   localparam logic [7:0] OFS_PRIMARY   = 8'h04;
   localparam logic [7:0] OFS_SECONDARY = 8'h05;
   localparam logic [7:0] OFS_DIRECTION = 8'h06;
   localparam logic [7:0] OFS_LEVEL     = 8'h07;
   localparam logic [7:0] OFS_EXT_DIM   = 8'h2B;
   // control register fields
   localparam int BIT_FADE_RATE   = 5;
   localparam int BIT_FADE_TARGET = 4;
   localparam int BIT_FADE_EN     = 3;
   localparam int BIT_SHARED      = 2;
   localparam int BIT_EN_PRIMARY  = 1;
   localparam int BIT_EN_SECOND   = 0;
   // direction register field
   localparam int BIT_DIM_PIN_EN  = 4;
   // external dimming enable register fields (own layout)
   localparam int BIT_DIM_PRIMARY = 0;
   localparam int BIT_DIM_SECOND  = 1;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [7:0] CODE_MAX    = 8'hFF;
   // fade timing
   localparam int CLOCK_HZ        = 100_000_000;
   localparam int FADE_SLOW_MS    = 1300;
   localparam int FADE_FAST_MS    = 650;
   localparam int FADE_STEPS      = 255;
   localparam int STEP_SLOW_CYC   = int'((64'(FADE_SLOW_MS) * CLOCK_HZ) / 1000 / FADE_STEPS);
   localparam int STEP_FAST_CYC   = int'((64'(FADE_FAST_MS) * CLOCK_HZ) / 1000 / FADE_STEPS);
   localparam int PIN_COUNT       = 3;
endpackage

// File: logic/fade_if.sv
`timescale 1ns/100ps
// Purpose: carries one fade channel's target and result
// Assumes: single clock domain
// Notes: ctrl drives target and mode, ramp returns the live code
interface fade_if;
   logic [7:0] target;
   logic       fade_on;
   logic       fast;
   logic       tick;
   logic [7:0] code;
   modport ctrl (output target, output fade_on, output fast, output tick, input code);
   modport ramp (input target, input fade_on, input fast, input tick, output code);
endinterface

// File: logic/fade_ramp.sv
`timescale 1ns/100ps
// Purpose: steps one live current code toward its target
// Assumes: tick comes from shared step timer
// Notes: one code per tick keeps rate fixed for any span
module fade_ramp
   import bl_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic ce,
   fade_if.ramp      ch
);
   logic [7:0] code_q;
   logic [7:0] code_d;
   wire        go_up   = code_q < ch.target;
   wire        go_down = code_q > ch.target;

   // step toward target or jump when fading off
   always_comb
   begin
      code_d = code_q;
      if (!ch.fade_on)
         code_d = ch.target;
      else if (ch.tick && go_up)
         code_d = code_q + 8'h01;
      else if (ch.tick && go_down)
         code_d = code_q - 8'h01;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         code_q <= RESET_VALUE;
      else if (ce)
         code_q <= code_d;
   end

   assign ch.code = code_q;

   one_step_a: assert property (@(posedge clock) disable iff (rst)
      ce && ch.fade_on && !ch.tick |=> code_q == $past(code_q))
      else $error("code moved without tick");
   direct_a: assert property (@(posedge clock) disable iff (rst)
      ce && !ch.fade_on |=> code_q == $past(ch.target))
      else $error("code not applied at once");
endmodule

// File: bench/host_port_model.sv
// Purpose: host side of the byte register port
// Assumes: design samples strobes on the rising clock edge
// Notes: write data is scrambled once a transfer is over
`timescale 1ns/100ps
module host_port_model
(
   input  wire logic       clock,
   output logic      [7:0] reg_addr,
   output logic            reg_write,
   output logic      [7:0] reg_wdata,
   output logic            reg_read,
   input  wire logic [7:0] reg_rdata
);
   // idle port at time zero
   initial
   begin
      reg_addr  = 8'h00;
      reg_write = 1'b0;
      reg_wdata = 8'h00;
      reg_read  = 1'b0;
   end

   // one write strobe held across one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge clock);
      #1;
      reg_write = 1'b0;
      reg_wdata = ~d; // no stale data after release
   endtask

   // read strobe, registered data taken after the read edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_read = 1'b1;
      @(posedge clock);
      #1;
      reg_read = 1'b0;
      d        = reg_rdata;
   endtask
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench for the backlight and pin register block
// Assumes: step counts shortened to 4 and 2 cycles
// Notes: undriven pins take their level from ext_pin
`timescale 1ns/100ps
module testbench;
   import bl_pkg::*;
   logic       clock = 1'b0;
   logic       rst   = 1'b1;
   logic       ce    = 1'b1;
   logic [7:0] reg_addr;
   logic       reg_write;
   logic [7:0] reg_wdata;
   logic       reg_read;
   logic [7:0] reg_rdata;
   logic       reg_hit;
   logic [2:0] pin_in;
   logic [2:0] pin_out;
   logic [2:0] pin_oe;
   logic [2:0] ext_pin = 3'h5;
   logic [7:0] primary_code;
   logic [7:0] secondary_code;
   logic       primary_on;
   logic       secondary_on;
   logic [7:0] v;
   int         cycles    = 0;
   int         bad_count = 0;
   int         n_tests   = 0;

   // clock and pin wire resolution
   always #5 clock = ~clock;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pin);

   backlight_fade_gpio_ctrl #(.STEP_SLOW(4), .STEP_FAST(2)) u_backlight_fade_gpio_ctrl (
      .clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .primary_code(primary_code),
      .secondary_code(secondary_code), .primary_on(primary_on),
      .secondary_on(secondary_on));

   host_port_model host (
      .clock(clock), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
      .reg_read(reg_read), .reg_rdata(reg_rdata));

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, v);
      chk("read data", v, exp);
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         summarize();
      end
   end

   // main sequence
   initial
   begin
      repeat (2) @(posedge clock);
      #1;
      rst = 1'b0;
      for (int a = 3; a < 7; a++) rchk(8'(a), 8'h00);
      rchk(OFS_LEVEL, 8'h05);
      chk("pin oe", {5'h00, pin_oe}, 8'h00);
      host.wr(OFS_CONTROL, 8'hFF);
      rchk(OFS_CONTROL, 8'h3F);
      rchk(8'h08, 8'h00);
      chk("hit", {7'h00, reg_hit}, 8'h00);
      host.wr(OFS_CONTROL, 8'h03);
      host.wr(OFS_PRIMARY, 8'h00);
      host.wr(OFS_SECONDARY, 8'h25);
      waitc(3);
      chk("enables", {6'h00, primary_on, secondary_on}, 8'h03);
      chk("secondary", secondary_code, 8'h25);
      // slow full-scale fade on primary
      host.wr(OFS_CONTROL, 8'h0B);
      host.wr(OFS_PRIMARY, 8'hFF);
      waitc(1000);
      chk("slow mid", {7'h00, primary_code >= 8'hF8 && primary_code <= 8'hFC}, 8'h01);
      waitc(40);
      chk("slow end", primary_code, 8'hFF);
      // fast partial fade keeps the rate
      host.wr(OFS_CONTROL, 8'h2B);
      host.wr(OFS_PRIMARY, 8'h80);
      waitc(240);
      chk("fast mid", {7'h00, primary_code > 8'h80}, 8'h01);
      waitc(30);
      chk("fast end", primary_code, 8'h80);
      chk("other string", secondary_code, 8'h25);
      // fade target secondary
      host.wr(OFS_CONTROL, 8'h1B);
      host.wr(OFS_SECONDARY, 8'h00);
      host.wr(OFS_PRIMARY, 8'h40);
      waitc(3);
      chk("no fade", primary_code, 8'h40);
      chk("sec ramp", {7'h00, secondary_code > 8'h18}, 8'h01);
      waitc(170);
      chk("sec end", secondary_code, 8'h00);
      // shared mode fades both strings
      host.wr(OFS_CONTROL, 8'h2F);
      waitc(200);
      chk("shared", secondary_code, 8'h40);
      host.wr(OFS_PRIMARY, 8'h00);
      waitc(60);
      chk("both mid", {7'h00, primary_code != 0 && secondary_code == primary_code}, 8'h01);
      waitc(100);
      chk("both end primary", primary_code, 8'h00);
      chk("both end secondary", secondary_code, 8'h00);
      // pins
      host.wr(OFS_DIRECTION, 8'h07);
      host.wr(OFS_LEVEL, 8'h05);
      chk("oe", {5'h00, pin_oe}, 8'h07);
      chk("out", {5'h00, pin_out}, 8'h05);
      waitc(2);
      rchk(OFS_LEVEL, 8'h05);
      chk("hit", {7'h00, reg_hit}, 8'h01);
      host.wr(OFS_DIRECTION, 8'h02);
      host.wr(OFS_LEVEL, 8'h02);
      waitc(2);
      rchk(OFS_LEVEL, 8'h07);
      ext_pin = 3'h0;
      waitc(3);
      rchk(OFS_LEVEL, 8'h02);
      // external dimming on pin 0
      host.wr(OFS_EXT_DIM, 8'h01);
      host.wr(OFS_DIRECTION, 8'h11);
      host.wr(OFS_CONTROL, 8'h03);
      chk("dim oe", {5'h00, pin_oe}, 8'h00);
      rchk(OFS_DIRECTION, 8'h11);
      waitc(4);
      chk("dim low", {6'h00, primary_on, secondary_on}, 8'h01);
      ext_pin = 3'h1;
      waitc(4);
      chk("dim high", {6'h00, primary_on, secondary_on}, 8'h03);
      host.wr(OFS_DIRECTION, 8'h17);
      chk("dim pins", {5'h00, pin_oe}, 8'h06);
      // clock enable low: a write is ignored
      ce = 1'b0;
      host.wr(OFS_EXT_DIM, 8'h02);
      ce = 1'b1;
      rchk(OFS_EXT_DIM, 8'h01);
      // reset in mid-run
      rst = 1'b1;
      waitc(2);
      chk("rst oe", {5'h00, pin_oe}, 8'h00);
      chk("rst on", {6'h00, primary_on, secondary_on}, 8'h00);
      rst = 1'b0;
      rchk(OFS_CONTROL, 8'h00);
      summarize();
   end
endmodule
